/* mode_ctrl.sv */
/*
 * operating-mode controller: state machine over normal, standby or sleep,
 * temporary shutdown and thermal shutdown, block enables per mode, and a
 * small register port for the control and diagnostic bits.
 * assumes all inputs except reset_n are synchronous to clk; temperature and supply levels
 * come from analog comparators; factory straps are stable after reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl
   import mode_ctrl_pkg::*;
#(
   parameter int WAKE_COUNT = WAKE_CYCLES,
   parameter int TSD_COUNT  = TSD_CYCLES
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // host pins
   input  wire logic       en,
   input  wire logic       tx,
   // bus level, low is dominant
   input  wire logic       lin_rx,
   // analog monitors
   input  wire logic       supply_ok,
   input  wire logic       temp_warn,
   input  wire logic       overtemp_flag,
   input  wire logic       temp_below_ret,
   // factory straps
   input  wire logic       otp_sleep_sel,
   input  wire logic       otp_tsd_enable,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // block enables
   output logic            reg_enable,
   output logic            reg_lowpower,
   output logic            vcc_pulldown,
   output logic            xcvr_enable,
   output logic            lin_drive_low,
   output logic            slew_low,
   output logic            wwd_enable,
   output logic            txwd_enable,
   output logic            divider_enable,
   output logic            relay_enable,
   output logic            reset_unit_enable,
   output logic            wake_det_enable,
   output logic            otmon_enable,
   output logic            osc_enable,
   // current mode
   output logic      [2:0] mode
);
   typedef struct packed {
      mode_t      state;
      // straps latched once per reset release
      logic       straps_taken;
      logic       sleep_sel;
      logic       tsd_allowed;
      logic       en_prev;
      // low-power request pending after en fell
      logic       armed;
      // software-visible control and diagnostic bits
      logic [1:0] ctrl;
      logic [1:0] diag;
      logic [7:0] rdata;
      logic       reg_enable;
      logic       reg_lowpower;
      logic       vcc_pulldown;
      logic       xcvr_enable;
      logic       lin_drive_low;
      logic       slew_low;
      logic       wwd_enable;
      logic       txwd_enable;
      logic       divider_enable;
      logic       relay_enable;
      logic       reset_unit_enable;
      logic       wake_det_enable;
      logic       otmon_enable;
      logic       osc_enable;
   } ctrl_state_t;

   ctrl_state_t s_q, s_d;
   logic        rst_n;
   logic        wake_done;
   logic        tsd_done;
   logic        hold_done;
   logic        wake_run;
   logic        tsd_run;
   logic        hold_run;

   reset_sync u_reset_sync (
      .clk        (clk),
      .reset_n    (reset_n),
      .rst_sync_n (rst_n)
   );

   // bus held dominant while the wake detector is powered
   assign wake_run = (s_q.state == STANDBY || s_q.state == SLEEP) && !lin_rx;
   assign tsd_run  = (s_q.state == TEMP_SD);
   // en low and tx recessive must last the whole hold time
   assign hold_run = (s_q.state == NORMAL) && s_q.armed && !en && tx;

   hold_timer #(
      .LIMIT (WAKE_COUNT)
   ) u_wake_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (wake_run),
      .done  (wake_done)
   );

   hold_timer #(
      .LIMIT (TSD_COUNT)
   ) u_tsd_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (tsd_run),
      .done  (tsd_done)
   );

   hold_timer #(
      .LIMIT (HOLD_CYCLES)
   ) u_hold_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (hold_run),
      .done  (hold_done)
   );

   always_comb begin
      logic en_rise;
      logic en_fall;
      logic tsd_req;
      en_rise = 1'b0;
      en_fall = 1'b0;
      tsd_req = 1'b0;
      s_d     = s_q;

      // en_prev resets low, the pin's pull-down idle level
      en_rise    = en && !s_q.en_prev;
      en_fall    = !en && s_q.en_prev;
      s_d.en_prev = en;

      // straps caught once after reset release
      if (!s_q.straps_taken) begin
         s_d.straps_taken = 1'b1;
         s_d.sleep_sel    = otp_sleep_sel;
         s_d.tsd_allowed  = otp_tsd_enable;
      end

      // register writes
      if (wr) begin
         if (addr == CTRL_ADDR) begin
            s_d.ctrl[CTRL_TSD_BIT]  = wdata[CTRL_TSD_BIT];
            s_d.ctrl[CTRL_SLEW_BIT] = wdata[CTRL_SLEW_BIT];
         end else if (addr == DIAG_ADDR) begin
            s_d.diag[DIAG_WARN_BIT] = s_q.diag[DIAG_WARN_BIT] & ~wdata[DIAG_WARN_BIT];
            s_d.diag[DIAG_OT_BIT]   = s_q.diag[DIAG_OT_BIT] & ~wdata[DIAG_OT_BIT];
         end
      end

      // warning flag, set wins over a clearing write
      if (s_q.state == NORMAL && temp_warn) begin
         s_d.diag[DIAG_WARN_BIT] = 1'b1;
      end

      tsd_req = s_q.ctrl[CTRL_TSD_BIT] && s_q.tsd_allowed;

      // arming of the low-power request
      if (s_q.state != NORMAL || en_rise || hold_done) begin
         s_d.armed = 1'b0;
      end else if (en_fall) begin
         s_d.armed = 1'b1;
      end

      // state transitions, highest priority first
      if (!supply_ok) begin
         s_d.state = POWER_OFF;
         s_d.ctrl  = CTRL_RESET;
         s_d.diag  = DIAG_RESET;
         s_d.armed = 1'b0;
      end else begin
         case (s_q.state)
            POWER_OFF: begin
               s_d.state = NORMAL;
            end
            NORMAL: begin
               if (overtemp_flag) begin
                  s_d.state = THERMAL_SD;
               end else if (tsd_req) begin
                  s_d.state = TEMP_SD;
               end else if (hold_done) begin
                  if (s_q.sleep_sel) begin
                     s_d.state = SLEEP;
                  end else begin
                     s_d.state = STANDBY;
                  end
               end
            end
            STANDBY: begin
               if (overtemp_flag) begin
                  s_d.state = THERMAL_SD;
               end else if (tsd_req) begin
                  s_d.state = TEMP_SD;
               end else if (en_rise || wake_done) begin
                  s_d.state = NORMAL;
               end
            end
            SLEEP: begin
               if (overtemp_flag) begin
                  s_d.state = THERMAL_SD;
               end else if (wake_done) begin
                  s_d.state = NORMAL;
               end
            end
            TEMP_SD: begin
               if (tsd_done) begin
                  s_d.state = NORMAL;
                  // hardware clear beats a write in the same cycle
                  s_d.ctrl[CTRL_TSD_BIT] = 1'b0;
               end
            end
            THERMAL_SD: begin
               // en and bus wakes are not looked at here
               if (temp_below_ret) begin
                  s_d.state = NORMAL;
               end
            end
            default: begin
               s_d.state = POWER_OFF;
            end
         endcase
      end

      // thermal entry records the event and drops the slew choice
      if (s_d.state == THERMAL_SD && s_q.state != THERMAL_SD) begin
         s_d.diag[DIAG_OT_BIT]    = 1'b1;
         s_d.ctrl[CTRL_SLEW_BIT]  = 1'b0;
      end

      // read data stands one cycle
      s_d.rdata = 8'h00;
      if (rd) begin
         if (addr == CTRL_ADDR) begin
            s_d.rdata = {6'h00, s_q.ctrl};
         end else if (addr == DIAG_ADDR) begin
            s_d.rdata = {6'h00, s_q.diag};
         end else if (addr == STATUS_ADDR) begin
            s_d.rdata = {5'h00, s_q.state};
         end
      end

      // block enables from the next state
      s_d.reg_enable        = 1'b0;
      s_d.reg_lowpower      = 1'b0;
      s_d.vcc_pulldown      = 1'b1;
      s_d.xcvr_enable       = 1'b0;
      s_d.lin_drive_low     = 1'b0;
      s_d.slew_low          = 1'b0;
      s_d.wwd_enable        = 1'b0;
      s_d.txwd_enable       = 1'b0;
      s_d.divider_enable    = 1'b0;
      s_d.relay_enable      = 1'b0;
      s_d.reset_unit_enable = 1'b0;
      s_d.wake_det_enable   = 1'b0;
      s_d.otmon_enable      = 1'b1;
      s_d.osc_enable        = 1'b1;
      case (s_d.state)
         POWER_OFF: begin
            s_d.otmon_enable = 1'b0;
            s_d.osc_enable   = 1'b0;
            s_d.vcc_pulldown = 1'b1;
         end
         NORMAL: begin
            s_d.reg_enable        = 1'b1;
            s_d.vcc_pulldown      = 1'b0;
            s_d.xcvr_enable       = 1'b1;
            s_d.lin_drive_low     = !tx;
            s_d.slew_low          = s_d.ctrl[CTRL_SLEW_BIT];
            s_d.wwd_enable        = 1'b1;
            s_d.txwd_enable       = 1'b1;
            s_d.divider_enable    = 1'b1;
            s_d.relay_enable      = 1'b1;
            s_d.reset_unit_enable = 1'b1;
         end
         STANDBY: begin
            s_d.reg_enable        = 1'b1;
            s_d.reg_lowpower      = 1'b1;
            s_d.vcc_pulldown      = 1'b0;
            s_d.reset_unit_enable = 1'b1;
            s_d.wake_det_enable   = 1'b1;
            s_d.otmon_enable      = 1'b1;
            s_d.xcvr_enable       = 1'b0;
         end
         SLEEP: begin
            s_d.reg_enable      = 1'b0;
            s_d.vcc_pulldown    = 1'b1;
            s_d.wake_det_enable = 1'b1;
            s_d.otmon_enable    = 1'b1;
         end
         TEMP_SD: begin
            s_d.vcc_pulldown    = 1'b1;
            s_d.wake_det_enable = 1'b0;
            s_d.lin_drive_low   = 1'b0;
         end
         THERMAL_SD: begin
            s_d.otmon_enable    = 1'b1;
            s_d.wake_det_enable = 1'b0;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q                   <= '0;
         s_q.state             <= POWER_OFF;
         s_q.vcc_pulldown      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata             = s_q.rdata;
   assign reg_enable        = s_q.reg_enable;
   assign reg_lowpower      = s_q.reg_lowpower;
   assign vcc_pulldown      = s_q.vcc_pulldown;
   assign xcvr_enable       = s_q.xcvr_enable;
   assign lin_drive_low     = s_q.lin_drive_low;
   assign slew_low          = s_q.slew_low;
   assign wwd_enable        = s_q.wwd_enable;
   assign txwd_enable       = s_q.txwd_enable;
   assign divider_enable    = s_q.divider_enable;
   assign relay_enable      = s_q.relay_enable;
   assign reset_unit_enable = s_q.reset_unit_enable;
   assign wake_det_enable   = s_q.wake_det_enable;
   assign otmon_enable      = s_q.otmon_enable;
   assign osc_enable        = s_q.osc_enable;
   assign mode              = s_q.state;
endmodule
`default_nettype wire

/* mode_ctrl_pkg.sv */
/*
 * constants for the operating-mode controller of the lin companion device:
 * register offsets and fields, reset values, state codes and timing counts.
 * assumes a 50 mhz clock.
 */
package mode_ctrl_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // least times, rounded up to whole cycles
   localparam int WAKE_TIME_NS  = 100000;
   localparam int WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TSD_TIME_MS   = 128;
   localparam int TSD_CYCLES    = (TSD_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_TIME_NS  = 10000;
   localparam int HOLD_CYCLES   = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W       = 24;

   localparam logic [7:0] CTRL_ADDR   = 8'h05;
   localparam logic [7:0] DIAG_ADDR   = 8'h06;
   localparam logic [7:0] STATUS_ADDR = 8'h07;
   localparam int         CTRL_TSD_BIT  = 0;
   localparam int         CTRL_SLEW_BIT = 1;
   localparam int         DIAG_WARN_BIT = 0;
   localparam int         DIAG_OT_BIT   = 1;
   localparam logic [1:0] CTRL_RESET  = 2'h0;
   localparam logic [1:0] DIAG_RESET  = 2'h0;

   typedef enum logic [2:0] {
      POWER_OFF  = 3'h0,
      NORMAL     = 3'h1,
      STANDBY    = 3'h2,
      SLEEP      = 3'h3,
      TEMP_SD    = 3'h4,
      THERMAL_SD = 3'h5
   } mode_t;
endpackage

/* reset_sync.sv */
/*
 * two-stage release synchroniser for the active-low reset.
 * assumes reset_n may be asserted at any time.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // synchronised reset
   output logic      rst_sync_n
);
   typedef struct packed {
      logic s1;
      logic s2;
   } sync_state_t;

   sync_state_t r_q, r_d;

   always_comb begin
      r_d    = r_q;
      r_d.s1 = 1'b1;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign rst_sync_n = r_q.s2;
endmodule
`default_nettype wire

/* hold_timer.sv */
/*
 * counts cycles while run is high; done rises once limit cycles have passed
 * and drops as soon as run falls. assumes a synchronised reset.
 */
`timescale 1ns/1ps
`default_nettype none
module hold_timer
   import mode_ctrl_pkg::*;
#(
   parameter int LIMIT = 1
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic run,
   output logic      done
);
   typedef struct packed {
      logic [TIMER_W-1:0] cnt;
      logic               done;
   } timer_state_t;

   timer_state_t t_q, t_d;

   always_comb begin
      t_d = t_q;
      if (!run) begin
         t_d.cnt  = '0;
         t_d.done = 1'b0;
      end else if (t_q.cnt >= TIMER_W'(LIMIT - 1)) begin
         t_d.done = 1'b1;
      end else begin
         t_d.cnt = t_q.cnt + TIMER_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   assign done = t_q.done;
endmodule
`default_nettype wire

/* mode_ctrl_checker.sv */
/* port assertions for the mode controller.
   bound to mode_ctrl from the testbench file. */
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_checker
   import mode_ctrl_pkg::*;
#(
   parameter int TSD_COUNT = 16
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   // stimulus
   input wire logic       tx,
   input wire logic       lin_rx,
   input wire logic       supply_ok,
   input wire logic       overtemp_flag,
   input wire logic       temp_below_ret,
   input wire logic       otp_tsd_enable,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   // enables and mode
   input wire logic       reg_enable,
   input wire logic       reg_lowpower,
   input wire logic       vcc_pulldown,
   input wire logic       xcvr_enable,
   input wire logic       lin_drive_low,
   input wire logic       slew_low,
   input wire logic       wwd_enable,
   input wire logic       txwd_enable,
   input wire logic       divider_enable,
   input wire logic       relay_enable,
   input wire logic       reset_unit_enable,
   input wire logic       wake_det_enable,
   input wire logic       otmon_enable,
   input wire logic       osc_enable,
   input wire logic [2:0] mode
);
   logic [TIMER_W-1:0] tsd_cnt_q;

   // cycles spent in temporary shutdown
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         tsd_cnt_q <= '0;
      else
         tsd_cnt_q <= (mode == TEMP_SD) ? tsd_cnt_q + 1'b1 : '0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence tsd_wr;
      wr && addr == CTRL_ADDR && wdata[CTRL_TSD_BIT] && supply_ok && !overtemp_flag
         && (mode == NORMAL || mode == STANDBY);
   endsequence
   sequence still_ok;
      supply_ok && !overtemp_flag;
   endsequence

   AST_NORMAL_ON: assert property (mode == NORMAL |-> reg_enable && !reg_lowpower
      && xcvr_enable && wwd_enable && divider_enable && relay_enable)
      else $error("normal mode enables wrong");
   AST_TX_RELAY: assert property (mode == NORMAL && $past(mode) == NORMAL
      |-> lin_drive_low == !$past(tx)) else $error("bus drive does not follow tx");
   AST_SLEW_NORMAL: assert property (slew_low |-> mode == NORMAL)
      else $error("low slew outside normal mode");
   AST_STANDBY: assert property (mode == STANDBY |-> reg_lowpower && wake_det_enable
      && otmon_enable && !xcvr_enable && !wwd_enable && !txwd_enable && !divider_enable
      && !relay_enable) else $error("standby enables wrong");
   AST_SLEEP: assert property (mode == SLEEP |-> !reg_enable && vcc_pulldown
      && !xcvr_enable && !divider_enable && !reset_unit_enable && !wwd_enable
      && wake_det_enable && osc_enable && otmon_enable) else $error("sleep enables wrong");
   AST_SLEEP_STAY: assert property (mode == SLEEP && lin_rx && $past(lin_rx)
      && supply_ok && !overtemp_flag |=> mode == SLEEP) else $error("sleep left without wake");
   AST_TSD_ENTRY: assert property (tsd_wr ##1 still_ok |=>
      (mode == TEMP_SD) == otp_tsd_enable) else $error("temp shutdown entry wrong");
   AST_TSD_STATE: assert property (mode == TEMP_SD |-> !reg_enable && vcc_pulldown
      && osc_enable && !xcvr_enable && !wake_det_enable && !lin_drive_low)
      else $error("temp shutdown enables wrong");
   AST_TSD_TIME: assert property (mode == TEMP_SD |-> tsd_cnt_q <= TSD_COUNT + 2)
      else $error("temp shutdown too long");
   AST_TSD_HOLD: assert property (mode == TEMP_SD && supply_ok && tsd_cnt_q < TSD_COUNT
      |=> mode == TEMP_SD) else $error("temp shutdown too short");
   AST_OT_ENTRY: assert property (supply_ok && overtemp_flag
      && (mode == NORMAL || mode == STANDBY || mode == SLEEP) |=> mode == THERMAL_SD)
      else $error("thermal entry missed");
   AST_OT_STATE: assert property (mode == THERMAL_SD |-> otmon_enable && !xcvr_enable
      && !wwd_enable && !txwd_enable && !reg_enable) else $error("thermal enables wrong");
   AST_OT_EXIT: assert property (mode == THERMAL_SD && supply_ok && !overtemp_flag
      |=> mode == ($past(temp_below_ret) ? NORMAL : THERMAL_SD)) else $error("thermal exit wrong");
   AST_POWER_OFF: assert property (!supply_ok |=> mode == POWER_OFF && !xcvr_enable)
      else $error("power off missed");
endmodule
`default_nettype wire

/* host_model.sv */
/* host microcontroller and bus wake source for the mode controller.
   assumes the register port of the controller never stalls. */
`timescale 1ns/1ps
`default_nettype none
module host_model
   import mode_ctrl_pkg::*;
#(
   parameter int WAKE_COUNT = 8
) (
   // clock
   input  wire logic       clk,
   // host pins and bus level
   output logic            en,
   output logic            tx,
   output logic            lin_rx,
   // register port
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   initial begin
      en = 1'b1;
      tx = 1'b1;
      lin_rx = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // en falls, tx held recessive past the hold time
   task automatic lowpower();
      @(posedge clk);
      en <= 1'b0;
      tx <= 1'b1;
      repeat (HOLD_CYCLES + 4) @(posedge clk);
   endtask

   task automatic wake_local();
      @(posedge clk);
      en <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   // bus dominant then released to its pull-up
   task automatic wake_remote();
      @(posedge clk);
      lin_rx <= 1'b0;
      repeat (WAKE_COUNT + 2) @(posedge clk);
      lin_rx <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   task automatic send_tx(input int n);
      repeat (n) begin
         @(posedge clk);
         tx <= 1'($urandom);
      end
      @(posedge clk);
      tx <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* tb.sv */
/* self-checking testbench for the mode controller.
   reads results back over the register port; checker bound below. */
`timescale 1ns/1ps
`default_nettype none
module tb
   import mode_ctrl_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       supply_ok = 1'b1;
   logic       temp_warn = 1'b0;
   logic       overtemp_flag = 1'b0;
   logic       temp_below_ret = 1'b0;
   logic       otp_sleep_sel = 1'b0;
   logic       otp_tsd_enable = 1'b0;
   logic       en, tx, lin_rx, wr, rd, rd_q = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic [7:0] exp_q[$];
   int         fails = 0;
   int         checks = 0;
   int         cyc = 0;
   int         seed;

   initial forever #10 clk = ~clk;

   host_model #(.WAKE_COUNT(8)) host (.clk(clk), .en(en), .tx(tx), .lin_rx(lin_rx),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

   mode_ctrl #(.WAKE_COUNT(8), .TSD_COUNT(40)) DUT (.clk(clk), .reset_n(reset_n),
      .en(en), .tx(tx), .lin_rx(lin_rx), .supply_ok(supply_ok), .temp_warn(temp_warn),
      .overtemp_flag(overtemp_flag), .temp_below_ret(temp_below_ret),
      .otp_sleep_sel(otp_sleep_sel), .otp_tsd_enable(otp_tsd_enable), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .reg_enable(), .reg_lowpower(),
      .vcc_pulldown(), .xcvr_enable(), .lin_drive_low(), .slew_low(), .wwd_enable(),
      .txwd_enable(), .divider_enable(), .relay_enable(), .reset_unit_enable(),
      .wake_det_enable(), .otmon_enable(), .osc_enable(), .mode());

   task automatic stop_test();
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk_rd(input logic [7:0] v);
      checks++;
      if (rdata !== v) begin
         fails++;
         $display("wrong value rdata expected %h seen %h", v, rdata);
      end
   endtask

   task automatic exp_rd(input logic [7:0] a, input logic [7:0] v);
      exp_q.push_back(v);
      host.rd_reg(a);
   endtask

   task automatic exp_mode(input mode_t m);
      exp_rd(STATUS_ADDR, {5'h00, m});
   endtask

   task automatic do_reset(input logic s, input logic t);
      @(posedge clk);
      reset_n <= 1'b0;
      otp_sleep_sel <= s;
      otp_tsd_enable <= t;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // read data stand one cycle after the strobe
   always @(posedge clk) begin
      if (rd_q && exp_q.size() > 0)
         chk_rd(exp_q.pop_front());
      rd_q <= rd;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      seed = $urandom(65);
      do_reset(1'b0, 1'b0);
      exp_mode(NORMAL);
      exp_rd(CTRL_ADDR, 8'h00);
      exp_rd(8'($urandom_range(255, 8)), 8'h00);
      host.send_tx(24);
      host.wr_reg(CTRL_ADDR, 8'h02);
      exp_rd(CTRL_ADDR, 8'h02);
      temp_warn <= 1'b1;
      exp_rd(DIAG_ADDR, 8'h01);
      temp_warn <= 1'b0;
      host.wr_reg(DIAG_ADDR, 8'h01);
      exp_rd(DIAG_ADDR, 8'h00);
      host.lowpower();
      exp_mode(STANDBY);
      host.wr_reg(CTRL_ADDR, 8'h01);
      exp_mode(STANDBY);
      host.wr_reg(CTRL_ADDR, 8'h00);
      host.wake_local();
      exp_mode(NORMAL);
      do_reset(1'b1, 1'b1);
      host.lowpower();
      exp_mode(SLEEP);
      host.wake_local();
      exp_mode(SLEEP);
      host.wake_remote();
      exp_mode(NORMAL);
      host.wr_reg(CTRL_ADDR, 8'h01);
      exp_mode(TEMP_SD);
      host.wake_remote();
      exp_mode(TEMP_SD);
      repeat (40) @(posedge clk);
      exp_mode(NORMAL);
      exp_rd(CTRL_ADDR, 8'h00);
      overtemp_flag <= 1'b1;
      exp_mode(THERMAL_SD);
      host.wake_remote();
      exp_mode(THERMAL_SD);
      exp_rd(DIAG_ADDR, 8'h02);
      overtemp_flag <= 1'b0;
      temp_below_ret <= 1'b1;
      exp_mode(NORMAL);
      temp_below_ret <= 1'b0;
      overtemp_flag <= 1'b1;
      supply_ok <= 1'b0;
      exp_mode(POWER_OFF);
      overtemp_flag <= 1'b0;
      supply_ok <= 1'b1;
      repeat (3) @(posedge clk);
      exp_mode(NORMAL);
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule

bind mode_ctrl mode_ctrl_checker #(.TSD_COUNT(TSD_COUNT)) chk (.*);
`default_nettype wire
